/* rtl/aab_pkg.sv */
package aab_pkg;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_ADD_CARRY = 6'h08;   // 0010 00da
  localparam logic [5:0] OPC_AND_REG   = 6'h05;   // 0001 01da
  localparam logic [7:0] OPC_AND_LIT   = 8'h0B;   // 0000 1011
  localparam logic [7:0] OPC_BR_CARRY  = 8'hE2;   // 1110 0010
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DEST_BIT   = 9;
  localparam int ACCESS_BIT = 8;
  // ---------------------------------------------------------------
  // Addressing constants
  // ---------------------------------------------------------------
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;    // Highest indexed offset
  localparam logic [7:0] ACCESS_SPLIT  = 8'h60;    // Upper access half starts here
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;    // Bank holding upper access half
  // ---------------------------------------------------------------
  // Reset values and phases
  // ---------------------------------------------------------------
  localparam logic [7:0]  ACCUM_RESET = 8'h00;
  localparam logic [20:0] PC_RESET    = 21'h000000;
  localparam logic [20:0] PC_STEP     = 21'h000002;
  localparam int          PHASES      = 4;
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } aab_phase_e;
endpackage : aab_pkg

/* rtl/aab_if.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Decoded instruction between decoder and core
// ---------------------------------------------------------------
interface aab_if;
  logic       is_add;      // Add with carry
  logic       is_andr;     // AND with register
  logic       is_andl;     // AND literal
  logic       is_br;       // Branch if carry
  logic       dest_mem;    // Result to memory
  logic [7:0] data_addr;   // Resolved low address byte
  logic [3:0] data_bank;   // Resolved bank
  logic       indexed;     // Indexed literal offset mode
  modport dec  (output is_add, is_andr, is_andl, is_br, dest_mem, data_addr, data_bank, indexed);
  modport core (input  is_add, is_andr, is_andl, is_br, dest_mem, data_addr, data_bank, indexed);
endinterface : aab_if

/* rtl/aab_decode.sv */
`timescale 1ns/1ps
module aab_decode
  import aab_pkg::*;
(
  input  wire logic [15:0] instr,       // Instruction word
  input  wire logic [3:0]  bank_sel,    // Bank select register
  input  wire logic [7:0]  index_base,  // Index pointer low byte
  input  wire logic        ext_en,      // Extended set enabled
  aab_if.dec               d
);
  // ---------------------------------------------------------------
  // Opcode match
  // ---------------------------------------------------------------
  assign d.is_add  = (instr[15:10] == OPC_ADD_CARRY);
  assign d.is_andr = (instr[15:10] == OPC_AND_REG);
  assign d.is_andl = (instr[15:8] == OPC_AND_LIT);
  assign d.is_br   = (instr[15:8] == OPC_BR_CARRY);
  assign d.dest_mem = instr[DEST_BIT];
  // Indexed mode only for access-bank form with extended set on
  assign d.indexed = ~instr[ACCESS_BIT] & ext_en &
                     (instr[7:0] <= INDEXED_LIMIT);
  // ---------------------------------------------------------------
  // Address resolution; indexed mode wraps in the low byte only
  // ---------------------------------------------------------------
  assign d.data_addr = d.indexed ? 8'(index_base + instr[7:0]) : instr[7:0];
  assign d.data_bank = instr[ACCESS_BIT] ? bank_sel :
                       (instr[7:0] >= ACCESS_SPLIT) ? ACCESS_HI_BANK : 4'h0;
endmodule : aab_decode

/* rtl/aab_core.sv */
`timescale 1ns/1ps
module aab_core
  import aab_pkg::*;
(
  input  wire logic        CLK,          // Core clock
  input  wire logic        RST,          // Sync reset, active high
  input  wire logic [15:0] INSTR,        // Fetched instruction word
  input  wire logic [3:0]  BANK_SEL,     // Bank select register
  input  wire logic [7:0]  INDEX_BASE,   // Index pointer low byte
  input  wire logic        EXT_EN,       // Extended set enable
  input  wire logic [7:0]  MEM_RDATA,    // Data memory read byte
  output logic [20:0]      PC,           // Program counter
  output logic [7:0]       ACCUM,        // Accumulator
  output logic [3:0]       MEM_BANK,     // Data memory bank
  output logic [7:0]       MEM_ADDR,     // Data memory address
  output logic             MEM_RD,       // Read strobe (phase 2)
  output logic             MEM_WR,       // Write strobe (phase 4)
  output logic [7:0]       MEM_WDATA,    // Write byte
  output logic             FLAG_N,       // Result msb
  output logic             FLAG_OV,      // Signed range
  output logic             FLAG_Z,       // Result null
  output logic             FLAG_DC,      // Nibble out
  output logic             FLAG_C,       // Adder msb out
  output logic [1:0]       PHASE,        // Current phase
  output logic             NOP_CYCLE     // Flushed second cycle
);
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  aab_if      dif ();                 // Decoded fields
  logic [15:0] instr_reg;             // Latched word
  aab_phase_e  phase_reg;             // Phase counter
  logic        flush_reg;             // Second cycle is a no-op
  logic [7:0]  oper_reg;              // Operand latched in phase 2
  logic [7:0]  res_reg;               // Result computed in phase 3
  logic [4:0]  flags_next;            // N OV Z DC C next values
  logic [8:0]  sum_full;              // Add with carry out
  logic [4:0]  sum_lo;                // Low nibble with carry
  logic [7:0]  res_next;              // Combinational result
  logic        taken;                 // Branch condition

  aab_decode u_dec (
    .instr      (instr_reg),
    .bank_sel   (BANK_SEL),
    .index_base (INDEX_BASE),
    .ext_en     (EXT_EN),
    .d          (dif)
  );

  // ---------------------------------------------------------------
  // Phase sequencing
  // ---------------------------------------------------------------
  // Four phases per instruction cycle; every instruction here is one word
  always_ff @(posedge CLK) begin
    if (RST) begin
      phase_reg <= PH_DECODE;
    end else begin
      phase_reg <= aab_phase_e'(2'(phase_reg + 2'h1));
    end
  end

  // Latch the instruction at the start of each cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      instr_reg <= 16'h0000;
    end else if (phase_reg == PH_WRITE) begin
      instr_reg <= INSTR;
    end
  end

  // Flush marks the cycle after a taken branch as a no-op
  always_ff @(posedge CLK) begin
    if (RST) begin
      flush_reg <= 1'b0;
    end else if (phase_reg == PH_WRITE) begin
      flush_reg <= ~flush_reg & dif.is_br & taken;
    end
  end

  assign taken = FLAG_C;

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  // Operand read in phase 2: literal or memory byte
  always_ff @(posedge CLK) begin
    if (RST) begin
      oper_reg <= 8'h00;
    end else if (phase_reg == PH_READ) begin
      oper_reg <= dif.is_andl ? instr_reg[7:0] : MEM_RDATA;
    end
  end

  // Arithmetic; digit carry and overflow per usual 8-bit practice
  always_comb begin
    sum_full = 9'(ACCUM) + 9'(oper_reg) + 9'(FLAG_C);
    sum_lo   = 5'(ACCUM[3:0]) + 5'(oper_reg[3:0]) + 5'(FLAG_C);
    res_next = (dif.is_add) ? sum_full[7:0] : (ACCUM & oper_reg);
    flags_next[4] = res_next[7];
    flags_next[3] = (ACCUM[7] == oper_reg[7]) && (res_next[7] != ACCUM[7]);
    flags_next[2] = (res_next == 8'h00);
    flags_next[1] = sum_lo[4];
    flags_next[0] = sum_full[8];
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      res_reg <= 8'h00;
    end else if (phase_reg == PH_PROCESS) begin
      res_reg <= res_next;
    end
  end

  // ---------------------------------------------------------------
  // Write back in phase 4, flags in phase 3
  // ---------------------------------------------------------------
  // Accumulator destination for literal AND, or for add and register AND when destination bit is 0
  always_ff @(posedge CLK) begin
    if (RST) begin
      ACCUM <= ACCUM_RESET;
    end else if (phase_reg == PH_WRITE && !flush_reg) begin
      if (dif.is_andl || ((dif.is_add || dif.is_andr) && !dif.dest_mem)) begin
        ACCUM <= res_reg;
      end
    end
  end

  // Flags: add updates all five, AND updates N and Z, branch none
  always_ff @(posedge CLK) begin
    if (RST) begin
      FLAG_N  <= 1'b0;
      FLAG_OV <= 1'b0;
      FLAG_Z  <= 1'b0;
      FLAG_DC <= 1'b0;
      FLAG_C  <= 1'b0;
    end else if (phase_reg == PH_PROCESS && !flush_reg) begin
      if (dif.is_add) begin
        FLAG_OV <= flags_next[3];
        FLAG_DC <= flags_next[1];
        FLAG_C  <= flags_next[0];
      end
      if (dif.is_add || dif.is_andr || dif.is_andl) begin
        FLAG_N <= flags_next[4];
        FLAG_Z <= flags_next[2];
      end
    end
  end

  // Program counter: step each cycle, branch target written in phase 4
  always_ff @(posedge CLK) begin
    if (RST) begin
      PC <= PC_RESET;
    end else if (phase_reg == PH_WRITE) begin
      if (!flush_reg && dif.is_br && taken) begin
        PC <= 21'(PC + PC_STEP + 21'({{13{instr_reg[7]}}, instr_reg[7:0]} << 1));
      end else begin
        PC <= 21'(PC + PC_STEP);
      end
    end
  end

  // Memory address, strobes and write data
  always_ff @(posedge CLK) begin
    if (RST) begin
      MEM_BANK  <= 4'h0;
      MEM_ADDR  <= 8'h00;
      MEM_RD    <= 1'b0;
      MEM_WR    <= 1'b0;
      MEM_WDATA <= 8'h00;
    end else begin
      MEM_BANK  <= dif.data_bank;
      MEM_ADDR  <= dif.data_addr;
      MEM_RD    <= (phase_reg == PH_DECODE) && !flush_reg && (dif.is_add || dif.is_andr);
      MEM_WR    <= (phase_reg == PH_PROCESS) && !flush_reg &&
                   (dif.is_add || dif.is_andr) && dif.dest_mem;
      MEM_WDATA <= res_next;
    end
  end

  // Status outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      PHASE     <= 2'b00;
      NOP_CYCLE <= 1'b0;
    end else begin
      PHASE     <= 2'(phase_reg + 2'h1);
      NOP_CYCLE <= (phase_reg == PH_WRITE) ? (~flush_reg & dif.is_br & taken) : flush_reg;
    end
  end
endmodule : aab_core

/* testbench/aab_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Phase, strobe and flag timing checks
// ----------------------------------------
module aab_chk (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [20:0] PC,
  input wire logic [7:0]  ACCUM,
  input wire logic        MEM_RD,
  input wire logic        MEM_WR,
  input wire logic        FLAG_N,
  input wire logic        FLAG_OV,
  input wire logic        FLAG_Z,
  input wire logic        FLAG_DC,
  input wire logic        FLAG_C,
  input wire logic [1:0]  PHASE,
  input wire logic        NOP_CYCLE
);
  wire [4:0] flg = {FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C}; // Packed flags
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Two settled edges first, since phase may idle at 0 just after reset
  AST_PHASE_ROT: assert property (!$past(RST) && !$past(RST, 2) |-> PHASE == $past(PHASE) + 2'h1)
    else $error("phase out of order");
  AST_RD_PH: assert property (MEM_RD |-> PHASE == 2'h1)
    else $error("read outside read phase");
  AST_WR_PH: assert property (MEM_WR |-> PHASE == 2'h3 && $past(MEM_RD, 2))
    else $error("write without read or outside write phase");
  AST_FLG_HOLD: assert property (PHASE != 2'h2 |=> $stable(flg))
    else $error("flags moved outside process phase");
  AST_ACC_HOLD: assert property (PHASE != 2'h3 |=> $stable(ACCUM))
    else $error("accumulator moved outside write phase");
  AST_PC_HOLD: assert property (PHASE != 2'h3 |=> $stable(PC))
    else $error("counter moved outside write phase");
  AST_PC_EVEN: assert property (PC[0] == 1'b0)
    else $error("odd counter");
  AST_NOP_MEM: assert property (NOP_CYCLE |-> !MEM_RD && !MEM_WR)
    else $error("memory access in flushed cycle");
  AST_NOP_HOLD: assert property (NOP_CYCLE && PHASE == 2'h2 |=> $stable(flg) ##1 $stable(ACCUM))
    else $error("flushed cycle changed state");
  AST_JUMP_NOP: assert property (PHASE == 2'h3 ##1 PC != $past(PC) + 21'h2 |-> NOP_CYCLE)
    else $error("jump not followed by flushed cycle");
endmodule : aab_chk
bind aab_core aab_chk u_chk (.*);

/* testbench/aab_mem.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Data memory beside the core
// ----------------------------------------
module aab_mem (
  input wire logic       CLK,
  input wire logic [3:0] MEM_BANK,
  input wire logic [7:0] MEM_ADDR,
  input wire logic       MEM_RD,
  input wire logic       MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  output logic [7:0]     MEM_RDATA
);
  logic [7:0] mem [0:4095]; // Sixteen banks of 256 bytes
  logic [7:0] last = 8'h00; // Last byte read
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'(i >> 4);
  // Writeback of results
  always @(posedge CLK) if (MEM_WR) mem[{MEM_BANK, MEM_ADDR}] <= MEM_WDATA;
  always @(posedge CLK) if (MEM_RD) last <= MEM_RDATA;
  // Idle bus shows the inverse so a stale capture cannot pass
  assign MEM_RDATA = MEM_RD ? mem[{MEM_BANK, MEM_ADDR}] : ~last;
endmodule : aab_mem

/* testbench/add_and_branch_instruction_slice_bench.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Random instruction stream with scoreboard
// ----------------------------------------
module add_and_branch_instruction_slice_bench import aab_pkg::*;;
  typedef struct {int due; logic [20:0] pc; logic [7:0] acc; logic [4:0] fl;
                  logic wr; logic [11:0] wa; logic [7:0] wd;} aab_exp_s;
  logic        CLK = 0, RST = 1, EXT_EN = 0;
  logic [15:0] INSTR = 16'h0000;
  logic [3:0]  BANK_SEL = 4'h0, MEM_BANK;
  logic [7:0]  INDEX_BASE = 8'h00, MEM_RDATA, ACCUM, MEM_ADDR, MEM_WDATA, am = 8'h00;
  logic [20:0] PC, pcm;
  logic [1:0]  PHASE, pph;
  logic        MEM_RD, MEM_WR, FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C, NOP_CYCLE;
  logic        fn = 0, fo = 0, fz = 0, fd = 0, fc = 0, fl = 0, go = 0; // Model flags
  int          icyc, cyc, err_count, comparisons, k;
  logic [31:0] w;
  aab_exp_s    q[$], em;
  logic [7:0]  sh [0:4095]; // Shadow of data memory
  aab_core DUT (.*);
  aab_mem u_mem (.*);
  always #10 CLK = ~CLK;
  task chk(input logic [63:0] a, input logic [63:0] b);
    comparisons++;
    if (a !== b) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, a, b);
    end
  endtask : chk
  task wrap_up;
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Issue one word in phase 3 and note its expected outcome
  task step(input logic [15:0] ins, input logic [3:0] bs, input logic [7:0] ib, input logic ex);
    aab_exp_s e; logic [11:0] ad; logic [7:0] v, r; logic [8:0] s; logic [4:0] h; logic tk, st, mo;
    @(negedge CLK);
    while (PHASE !== 2'h2) @(negedge CLK);
    @(posedge CLK);
    INSTR <= ins;
    BANK_SEL <= bs;
    INDEX_BASE <= ib;
    EXT_EN <= ex;
    if (!go) pcm = 21'((icyc + 1) * 2);
    go = 1;
    ad = ins[ACCESS_BIT] ? {bs, ins[7:0]}
       : (ex && ins[7:0] <= INDEXED_LIMIT) ? {4'h0, ib + ins[7:0]}
       : {(ins[7:0] >= ACCESS_SPLIT) ? ACCESS_HI_BANK : 4'h0, ins[7:0]};
    v = sh[ad];
    {tk, st, mo, r} = 11'h000;
    e.wr = 0;
    e.wa = ad;
    e.wd = 0;
    if (!fl && ins[15:10] == OPC_ADD_CARRY) begin
      s = {1'b0, am} + {1'b0, v} + 9'(fc);
      h = {1'b0, am[3:0]} + {1'b0, v[3:0]} + 5'(fc);
      fo = (am[7] == v[7]) && (s[7] != am[7]);
      {fc, fd, r, st, mo} = {s[8], h[4], s[7:0], 2'b11};
    end else if (!fl && ins[15:10] == OPC_AND_REG) {r, st, mo} = {am & v, 2'b11};
    else if (!fl && ins[15:8] == OPC_AND_LIT) {r, st} = {am & ins[7:0], 1'b1};
    else if (!fl && ins[15:8] == OPC_BR_CARRY) tk = fc;
    if (st) begin
      fn = r[7];
      fz = (r == 8'h00);
      if (mo && ins[DEST_BIT]) {sh[ad], e.wr, e.wd} = {r, 1'b1, r};
      else am = r;
    end
    // Taken target is the already stepped counter plus twice the offset
    e.pc = pcm + PC_STEP + (tk ? {{12{ins[7]}}, ins[7:0], 1'b0} : 21'h000000);
    pcm = e.pc;
    fl = tk; // Next word is flushed
    e.due = icyc + 2;
    e.acc = am;
    e.fl = {fn, fo, fz, fd, fc};
    q.push_back(e);
  endtask : step
  // Outcome watcher, results land on the edge leaving phase 3
  always @(negedge CLK) begin
    if (!RST && PHASE === 2'h3 && q.size() > 0 && q[0].due == icyc + 1) begin
      chk(64'(MEM_WR), 64'(q[0].wr));
      if (q[0].wr) chk(64'({MEM_BANK, MEM_ADDR, MEM_WDATA}), 64'({q[0].wa, q[0].wd}));
    end
    if (!RST && PHASE === 2'h0 && pph === 2'h3) begin
      icyc++;
      if (q.size() > 0 && q[0].due == icyc) begin
        em = q.pop_front();
        chk(64'({PC, ACCUM, FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C}), 64'({em.pc, em.acc, em.fl}));
      end
    end
    pph = PHASE;
  end
  // Hang guard, a full run needs under 3000 cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    for (int i = 0; i < 4096; i++) sh[i] = 8'(i) ^ 8'(i >> 4);
    void'($urandom(32'h7160));
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    repeat (300) begin
      w = $urandom;
      k = $urandom_range(4);
      w[7:0] = w[31] ? w[7:0] : 8'h5F + 8'(w[30]); // Bias to the indexed limit
      step(k == 0 ? {OPC_ADD_CARRY, w[9:0]} : k == 1 ? {OPC_AND_REG, w[9:0]}
         : k == 2 ? {OPC_AND_LIT, w[7:0]} : k == 3 ? {OPC_BR_CARRY, w[7:0]}
         : {4'hF, w[11:0]}, w[15:12], w[23:16], w[24]);
    end
    repeat (12) @(posedge CLK);
    if (q.size() != 0) err_count++;
    wrap_up();
  end
endmodule : add_and_branch_instruction_slice_bench
